// ---- rtl/fhr_top.sv ----
/*
  Fault history recorder top: AXI4-Lite slave, capture, history and interrupt.
  Assumes fault events and measurements arrive synchronous to aclk from the drive control logic.
*/
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`include "fhr_consts.svh"

module fhr_top (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      fault_valid,
  input  wire logic [`FHR_CODE_W-1:0]    newest_fault_code,
  input  wire logic [`FHR_HOURS_W-1:0]   elapsed_hours_counter,
  input  wire logic [`FHR_MIN_W-1:0]     elapsed_minutes_counter,
  input  wire logic [`FHR_FREQ_W-1:0]    output_frequency_value,
  input  wire logic [`FHR_CURR_W-1:0]    output_current_value,
  input  wire logic [`FHR_VOLT_W-1:0]    dc_bus_voltage_value,
  input  wire logic [`FHR_STAT_W-1:0]    drive_status_word,
  input  wire logic [`FHR_ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic [2:0]                s_axi_awprot,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [`FHR_ADDR_W-1:0]    s_axi_araddr,
  input  wire logic [2:0]                s_axi_arprot,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output logic                           irq
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic [1:0]                  ctrl_r;
  logic [`FHR_IRQ_W-1:0]       irq_sts_r;
  logic [`FHR_IRQ_W-1:0]       irq_msk_r;
  logic                        have_r;
  logic                        clear_pls_r;
  logic                        aw_have_r;
  logic                        w_have_r;
  logic [`FHR_ADDR_W-1:0]      aw_addr_r;
  logic [31:0]                 w_data_r;
  logic [3:0]                  w_strb_r;
  logic                        wr_fire;
  logic                        wr_bad;
  logic                        rd_fire;
  logic [31:0]                 rd_word;
  logic                        rd_bad;
  logic [3:0]                  rd_slot;
  logic [1:0]                  rd_field;
  fhr_pkg::fhr_entry_type      snap;
  fhr_pkg::fhr_entry_type      rd_entry;
  fhr_pkg::fhr_entry_type      newest;
  logic [3:0]                  count;
  logic                        rec_pulse;
  logic                        dup_pulse;
  logic [`FHR_IRQ_W-1:0]       irq_set;

  // --------------------------------------------------------------------------
  // Address decode helpers
  // --------------------------------------------------------------------------
  function automatic logic is_hist(input logic [`FHR_ADDR_W-1:0] a);
    return (a >= `FHR_OFF_HIST) && (a < `FHR_HIST_END);
  endfunction

  function automatic logic [3:0] hist_slot(input logic [`FHR_ADDR_W-1:0] a);
    logic [`FHR_ADDR_W-1:0] d;
    d = a - `FHR_OFF_HIST;
    return d[7:4];
  endfunction

  // --------------------------------------------------------------------------
  // Capture and history
  // --------------------------------------------------------------------------
  fhr_capture u_capture (
    .aclk                    (aclk),
    .aresetn                 (aresetn),
    .enable                  (ctrl_r[`FHR_CTRL_EN]),
    .fault_valid             (fault_valid),
    .newest_fault_code       (newest_fault_code),
    .elapsed_hours_counter   (elapsed_hours_counter),
    .elapsed_minutes_counter (elapsed_minutes_counter),
    .output_frequency_value  (output_frequency_value),
    .output_current_value    (output_current_value),
    .dc_bus_voltage_value    (dc_bus_voltage_value),
    .drive_status_word       (drive_status_word),
    .have_entry              (have_r),
    .last_code               (newest.code),
    .snap                    (snap),
    .rec_pulse               (rec_pulse),
    .dup_pulse               (dup_pulse)
  );

  fhr_history u_history (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .push     (rec_pulse),
    .clear    (clear_pls_r),
    .din      (snap),
    .rd_slot  (rd_slot),
    .rd_entry (rd_entry),
    .newest   (newest),
    .count    (count)
  );

  // Tracks whether slot 0 is valid, so a first fault of code 0 is still logged.
  always_ff @(posedge aclk) begin
    if (!aresetn || clear_pls_r) begin
      have_r <= 1'b0;
    end else if (rec_pulse) begin
      have_r <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------------------
  // Address and data are taken in either order; the response follows both.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_have_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  always_comb begin
    wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
    wr_bad  = !(aw_addr_r == `FHR_OFF_CTRL || aw_addr_r == `FHR_OFF_IRQ_STS ||
                aw_addr_r == `FHR_OFF_IRQ_MSK);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `FHR_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_bad ? `FHR_RESP_SLVERR : `FHR_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------------
  // The clear bit self-clears; it wipes the history one cycle after the write.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r      <= `FHR_CTRL_RST;
      clear_pls_r <= 1'b0;
    end else begin
      clear_pls_r <= wr_fire && aw_addr_r == `FHR_OFF_CTRL && w_strb_r[0] && w_data_r[`FHR_CTRL_CLR];
      if (wr_fire && aw_addr_r == `FHR_OFF_CTRL && w_strb_r[0]) begin
        ctrl_r[`FHR_CTRL_EN] <= w_data_r[`FHR_CTRL_EN];
      end
      ctrl_r[`FHR_CTRL_CLR] <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt status, mask and output
  // --------------------------------------------------------------------------
  always_comb begin
    irq_set                 = '0;
    irq_set[`FHR_IRQ_NEW]   = rec_pulse;
    irq_set[`FHR_IRQ_DUP]   = dup_pulse;
    irq_set[`FHR_IRQ_FULL]  = rec_pulse && count == 4'(`FHR_DEPTH);
  end

  // A set in the same cycle as a write-one-to-clear wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_sts_r <= '0;
    end else if (wr_fire && aw_addr_r == `FHR_OFF_IRQ_STS && w_strb_r[0]) begin
      irq_sts_r <= (irq_sts_r & ~w_data_r[`FHR_IRQ_W-1:0]) | irq_set;
    end else begin
      irq_sts_r <= irq_sts_r | irq_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_msk_r <= '0;
    end else if (wr_fire && aw_addr_r == `FHR_OFF_IRQ_MSK && w_strb_r[0]) begin
      irq_msk_r <= w_data_r[`FHR_IRQ_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_sts_r & irq_msk_r);
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------------------
  // Each slot takes four words: code and status, hours and minutes, frequency and current, volts.
  always_comb begin
    rd_slot  = hist_slot(s_axi_araddr);
    rd_field = s_axi_araddr[3:2];
    rd_bad   = 1'b0;
    rd_word  = '0;
    if (is_hist(s_axi_araddr)) begin
      unique case (rd_field)
        2'h0: rd_word = {11'h000, rd_entry.status, 9'h000, rd_entry.code};
        2'h1: rd_word = {1'b0, rd_entry.hours, 4'h0, rd_entry.minutes};
        2'h2: rd_word = {rd_entry.curr, rd_entry.freq};
        2'h3: rd_word = {21'h000000, rd_entry.volts};
      endcase
    end else if (s_axi_araddr == `FHR_OFF_CTRL) begin
      rd_word = {30'h00000000, ctrl_r};
    end else if (s_axi_araddr == `FHR_OFF_STATUS) begin
      rd_word = {23'h000000, have_r, count, 4'h0};
    end else if (s_axi_araddr == `FHR_OFF_IRQ_STS) begin
      rd_word = {29'h00000000, irq_sts_r};
    end else if (s_axi_araddr == `FHR_OFF_IRQ_MSK) begin
      rd_word = {29'h00000000, irq_msk_r};
    end else if (s_axi_araddr == `FHR_OFF_COUNT) begin
      rd_word = {28'h0000000, count};
    end else if (s_axi_araddr == `FHR_OFF_ID) begin
      rd_word = `FHR_ID_VALUE;
    end else begin
      rd_bad = 1'b1;
    end
  end

  always_comb begin
    rd_fire = s_axi_arvalid && s_axi_arready;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !rd_fire && !s_axi_rvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `FHR_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_bad ? `FHR_RESP_SLVERR : `FHR_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  // A clear in the same cycle wins over the fault, so those cycles are left out.
  AST_NEW_CODE: assert property (@(posedge aclk) disable iff (!aresetn)
    (rec_pulse && !clear_pls_r) |=> newest.code == $past(newest_fault_code))
    else $error("newest slot does not hold the recorded code");
  AST_DUP_NO_SHIFT: assert property (@(posedge aclk) disable iff (!aresetn)
    (dup_pulse && !clear_pls_r) |=> $stable(count) && $stable(newest))
    else $error("repeated fault changed the history");
  AST_HOURS: assert property (@(posedge aclk) disable iff (!aresetn)
    (rec_pulse && !clear_pls_r) |=> newest.hours == $past(elapsed_hours_counter))
    else $error("hours snapshot wrong");
  AST_MIN_RANGE: assert property (@(posedge aclk) disable iff (!aresetn)
    newest.minutes <= `FHR_MIN_MAX)
    else $error("minutes snapshot out of range");
  AST_FREQ_RANGE: assert property (@(posedge aclk) disable iff (!aresetn)
    (rec_pulse && !clear_pls_r) |=>
    newest.freq <= `FHR_FREQ_MAX && newest.curr == $past(output_current_value))
    else $error("frequency or current snapshot wrong");
  AST_VOLT_STAT: assert property (@(posedge aclk) disable iff (!aresetn)
    (rec_pulse && !clear_pls_r) |=>
    newest.volts <= `FHR_VOLT_MAX && newest.status == $past(drive_status_word))
    else $error("voltage or status snapshot wrong");
  AST_COUNT_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
    (rec_pulse && !clear_pls_r && count < 4'(`FHR_DEPTH)) |=> count == $past(count) + 4'h1)
    else $error("entry count did not advance");
  AST_HIST_WRITE_ERR: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && is_hist(aw_addr_r)) |=> s_axi_bvalid && s_axi_bresp == `FHR_RESP_SLVERR)
    else $error("write to history slot was accepted");
  AST_IRQ_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn)
    |(irq_sts_r & irq_msk_r) |=> irq)
    else $error("interrupt missing");

  COV_RECORD: cover property (@(posedge aclk) disable iff (!aresetn) rec_pulse);
  COV_DUP:    cover property (@(posedge aclk) disable iff (!aresetn) dup_pulse);
  COV_FULL:   cover property (@(posedge aclk) disable iff (!aresetn) rec_pulse && count == 4'(`FHR_DEPTH));
  COV_IRQ:    cover property (@(posedge aclk) disable iff (!aresetn) irq);

endmodule

// ---- rtl/fhr_consts.svh ----
/*
  Register offsets, field widths, clamp limits and reset values of the fault history recorder.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef FHR_CONSTS_SVH
`define FHR_CONSTS_SVH

// ----------------------------------------------------------------------------
// History shape
// ----------------------------------------------------------------------------
`define FHR_DEPTH        10
`define FHR_CODE_W       7
`define FHR_HOURS_W      15
`define FHR_MIN_W        12
`define FHR_FREQ_W       16
`define FHR_CURR_W       16
`define FHR_VOLT_W       11
`define FHR_STAT_W       5
`define FHR_MIN_MAX      12'hc80
`define FHR_FREQ_MAX     16'hc350
`define FHR_VOLT_MAX     11'h4b0

// ----------------------------------------------------------------------------
// Register map, byte addresses
// ----------------------------------------------------------------------------
`define FHR_ADDR_W       12
`define FHR_OFF_CTRL     12'h000
`define FHR_OFF_STATUS   12'h004
`define FHR_OFF_IRQ_STS  12'h008
`define FHR_OFF_IRQ_MSK  12'h00c
`define FHR_OFF_COUNT    12'h010
`define FHR_OFF_ID       12'h014
`define FHR_OFF_HIST     12'h100
`define FHR_HIST_STRIDE  12'h010
`define FHR_HIST_END     12'h1a0

// ----------------------------------------------------------------------------
// Reset values and status bits
// ----------------------------------------------------------------------------
`define FHR_CTRL_RST     2'h1
`define FHR_CTRL_EN      0
`define FHR_CTRL_CLR     1
`define FHR_IRQ_NEW      0
`define FHR_IRQ_DUP      1
`define FHR_IRQ_FULL     2
`define FHR_IRQ_W        3
// Identification value; the value is arbitrary.
`define FHR_ID_VALUE     32'h0f4e_0001
`define FHR_RESP_OKAY    2'h0
`define FHR_RESP_SLVERR  2'h2

`endif

// ---- rtl/fhr_pkg.sv ----
/*
  Types shared by the fault history recorder modules.
  Assumes the constants header is on the include path.
*/
`include "fhr_consts.svh"

package fhr_pkg;

  // --------------------------------------------------------------------------
  // One history entry
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [`FHR_CODE_W-1:0]  code;
    logic [`FHR_HOURS_W-1:0] hours;
    logic [`FHR_MIN_W-1:0]   minutes;
    logic [`FHR_FREQ_W-1:0]  freq;
    logic [`FHR_CURR_W-1:0]  curr;
    logic [`FHR_VOLT_W-1:0]  volts;
    logic [`FHR_STAT_W-1:0]  status;
  } fhr_entry_type;

  typedef enum logic [1:0] {
    FHR_RD_IDLE,
    FHR_RD_RESP
  } fhr_rd_state_type;

endpackage

// ---- rtl/fhr_capture.sv ----
/*
  Fault event capture: forms a clamped snapshot and decides whether the event is recorded.
  Assumes fault and measurement inputs come from logic on the same clock.
*/
`timescale 1ns/1ps
`include "fhr_consts.svh"

module fhr_capture (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      enable,
  input  wire logic                      fault_valid,
  input  wire logic [`FHR_CODE_W-1:0]    newest_fault_code,
  input  wire logic [`FHR_HOURS_W-1:0]   elapsed_hours_counter,
  input  wire logic [`FHR_MIN_W-1:0]     elapsed_minutes_counter,
  input  wire logic [`FHR_FREQ_W-1:0]    output_frequency_value,
  input  wire logic [`FHR_CURR_W-1:0]    output_current_value,
  input  wire logic [`FHR_VOLT_W-1:0]    dc_bus_voltage_value,
  input  wire logic [`FHR_STAT_W-1:0]    drive_status_word,
  input  wire logic                      have_entry,
  input  wire logic [`FHR_CODE_W-1:0]    last_code,
  output fhr_pkg::fhr_entry_type         snap,
  output logic                           rec_pulse,
  output logic                           dup_pulse
);

  // Snapshot is formed combinationally so that it reflects the cycle of the fault.
  always_comb begin
    snap.code    = newest_fault_code;
    snap.hours   = elapsed_hours_counter;
    snap.minutes = (elapsed_minutes_counter > `FHR_MIN_MAX) ? `FHR_MIN_MAX
                   : elapsed_minutes_counter;
    snap.freq    = (output_frequency_value > `FHR_FREQ_MAX) ? `FHR_FREQ_MAX
                   : output_frequency_value;
    snap.curr    = output_current_value;
    snap.volts   = (dc_bus_voltage_value > `FHR_VOLT_MAX) ? `FHR_VOLT_MAX
                   : dc_bus_voltage_value;
    snap.status  = drive_status_word;
  end

  // A fault equal to the newest entry is a repeat and is not logged again.
  always_comb begin
    dup_pulse = enable && fault_valid && have_entry && (newest_fault_code == last_code);
    rec_pulse = enable && fault_valid && !dup_pulse;
  end

endmodule

// ---- rtl/fhr_history.sv ----
/*
  Ten-deep shift history of fault entries, slot 0 newest.
  Assumes push and clear come from logic on the same clock.
*/
`timescale 1ns/1ps
`include "fhr_consts.svh"

module fhr_history (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       push,
  input  wire logic                       clear,
  input  fhr_pkg::fhr_entry_type          din,
  input  wire logic [3:0]                 rd_slot,
  output fhr_pkg::fhr_entry_type          rd_entry,
  output fhr_pkg::fhr_entry_type          newest,
  output logic [3:0]                      count
);

  fhr_pkg::fhr_entry_type mem_r [`FHR_DEPTH];
  logic [3:0]             count_r;

  // All fields move together; the entry in the last slot falls off.
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      for (int i = 0; i < `FHR_DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (push) begin
      mem_r[0] <= din;
      for (int i = 1; i < `FHR_DEPTH; i++) begin
        mem_r[i] <= mem_r[i-1];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      count_r <= 4'h0;
    end else if (push && count_r != 4'(`FHR_DEPTH)) begin
      count_r <= count_r + 4'h1;
    end
  end

  always_comb begin
    rd_entry = (rd_slot < 4'(`FHR_DEPTH)) ? mem_r[rd_slot] : '0;
    newest   = mem_r[0];
    count    = count_r;
  end

endmodule

// ---- tb/fhr_drive_model.sv ----
/* Stand-in for the drive control logic: running measurements and fault strobes.
   Assumes fire is called from the bench's own process on aclk. */
`timescale 1ns/1ps
`include "fhr_consts.svh"
module fhr_drive_model (
  input  wire logic                    aclk,
  output logic                         fault_valid,
  output logic [`FHR_CODE_W-1:0]       newest_fault_code,
  output logic [`FHR_HOURS_W-1:0]      elapsed_hours_counter,
  output logic [`FHR_MIN_W-1:0]        elapsed_minutes_counter,
  output logic [`FHR_FREQ_W-1:0]       output_frequency_value,
  output logic [`FHR_CURR_W-1:0]       output_current_value,
  output logic [`FHR_VOLT_W-1:0]       dc_bus_voltage_value,
  output logic [`FHR_STAT_W-1:0]       drive_status_word
);
  // ---------------------------------------------------------------------------
  // Measurements
  // ---------------------------------------------------------------------------
  // Every value moves each cycle, so a snapshot taken one edge early or late is seen.
  logic [15:0] seed_r = 16'h0000;
  initial fault_valid = 1'b0;
  initial newest_fault_code = 7'h00;
  always @(posedge aclk) seed_r <= seed_r + 16'h0001;
  assign elapsed_hours_counter   = seed_r[14:0];
  assign elapsed_minutes_counter = {1'b0, seed_r[10:0]};
  assign output_frequency_value  = {1'b0, seed_r[14:0]};
  assign output_current_value    = ~seed_r;
  // Bus voltage counts down from above the limit, so early faults exercise the clamp.
  assign dc_bus_voltage_value    = ~seed_r[10:0];
  assign drive_status_word       = seed_r[4:0];
  // One-cycle fault strobe; s returns the seed the recorder sees at the strobe.
  task automatic fire(input logic [6:0] c, output logic [15:0] s);
    @(posedge aclk);
    s = seed_r + 16'h0001;
    fault_valid       <= 1'b1;
    newest_fault_code <= c;
    @(posedge aclk);
    fault_valid       <= 1'b0;
    newest_fault_code <= ~c;
  endtask
endmodule

// ---- tb/fhr_top_bench.sv ----
/* Self-checking bench of the fault history recorder with an AXI4-Lite master.
   Assumes the design files and the drive stand-in are compiled before it. */
`timescale 1ns/1ps
`include "fhr_consts.svh"
module fhr_top_bench;
  logic                 aclk, aresetn, fault_valid, awvalid, wvalid, bready, arvalid, rready;
  logic                 awready, wready, bvalid, arready, rvalid, irq;
  logic [6:0]           newest_fault_code;
  logic [14:0]          elapsed_hours_counter;
  logic [11:0]          elapsed_minutes_counter, awaddr, araddr;
  logic [15:0]          output_frequency_value, output_current_value;
  logic [10:0]          dc_bus_voltage_value;
  logic [4:0]           drive_status_word;
  logic [31:0]          wdata, rdata, d;
  logic [1:0]           bresp, rresp, r;
  logic [15:0]          seeds [0:11];
  int                   err_total, samples_checked;

  fhr_drive_model DRV (.aclk, .fault_valid, .newest_fault_code, .elapsed_hours_counter, .elapsed_minutes_counter,
    .output_frequency_value, .output_current_value, .dc_bus_voltage_value, .drive_status_word);
  fhr_top DUT (.aclk, .aresetn, .fault_valid, .newest_fault_code, .elapsed_hours_counter, .elapsed_minutes_counter,
    .output_frequency_value, .output_current_value, .dc_bus_voltage_value, .drive_status_word, .irq,
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // ---------------------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [11:0] a);
    arvalid <= 1'b1;
    araddr  <= a;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!dd && wready === 1'b1) begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  // All four words of history slot n-1 against code c and the seed s at the fault.
  task automatic slot(input int n, input logic [6:0] c, input logic [15:0] s);
    logic [11:0] b;
    b = `FHR_OFF_HIST + 12'(n - 1) * `FHR_HIST_STRIDE;
    rc(b, {11'h000, s[4:0], 9'h000, c});
    rc(b + 12'h004, {1'b0, s[14:0], 5'h00, s[10:0]});
    rc(b + 12'h008, {~s, 1'b0, s[14:0]});
    rc(b + 12'h00c, {21'h000000, (~s[10:0] > `FHR_VOLT_MAX) ? `FHR_VOLT_MAX : ~s[10:0]});
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    rc(`FHR_OFF_CTRL, 32'h1);
    rc(`FHR_OFF_COUNT, 32'h0);
    rc(`FHR_OFF_ID, `FHR_ID_VALUE);
    rd(12'h020);
    chk({d[31:2], r}, {30'h0, `FHR_RESP_SLVERR});
  endtask
  task automatic t_fill();
    wr(`FHR_OFF_IRQ_MSK, 32'h1);
    for (int i = 0; i <= 10; i++) begin
      DRV.fire(7'(127 - 12 * i), seeds[i]);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, 32'h1);
    end
    rc(`FHR_OFF_COUNT, 32'ha);
    rc(`FHR_OFF_STATUS, 32'h1a0);
    rc(`FHR_OFF_IRQ_STS, 32'h5);
    for (int n = 1; n <= 10; n++) slot(n, 7'(127 - 12 * (11 - n)), seeds[11 - n]);
    wr(`FHR_OFF_IRQ_STS, 32'h7);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic t_dup();
    DRV.fire(7'h07, seeds[11]);
    repeat (2) @(posedge aclk);
    rc(`FHR_OFF_COUNT, 32'ha);
    rc(`FHR_OFF_IRQ_STS, 32'h2);
    slot(1, 7'h07, seeds[10]);
    DRV.fire(7'h40, seeds[11]);
    slot(1, 7'h40, seeds[11]);
    slot(2, 7'h07, seeds[10]);
  endtask
  task automatic t_ro();
    wr(`FHR_OFF_HIST, 32'hffff_ffff);
    chk({30'h0, r}, {30'h0, `FHR_RESP_SLVERR});
    slot(1, 7'h40, seeds[11]);
  endtask
  task automatic t_mask();
    wr(`FHR_OFF_IRQ_STS, 32'h7);
    wr(`FHR_OFF_IRQ_MSK, 32'h0);
    DRV.fire(7'h00, seeds[0]);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    rc(`FHR_OFF_IRQ_STS, 32'h5);
    slot(1, 7'h00, seeds[0]);
    wr(`FHR_OFF_CTRL, 32'h3);
    rc(`FHR_OFF_COUNT, 32'h0);
    rc(`FHR_OFF_CTRL, 32'h1);
    rc(`FHR_OFF_STATUS, 32'h0);
    wr(`FHR_OFF_CTRL, 32'h0);
    DRV.fire(7'h11, seeds[1]);
    rc(`FHR_OFF_COUNT, 32'h0);
    rc(`FHR_OFF_IRQ_STS, 32'h5);
  endtask

  task automatic stop_test();
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    stop_test();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 56'h0;
    err_total = 0;
    samples_checked = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_fill();
    t_dup();
    t_ro();
    t_mask();
    stop_test();
  end
endmodule
